/* File: rtl/mcsc_pkg.sv */
`default_nettype none
package mcsc_pkg;
    // ------------------------------------------------------------
    // serial word
    // ------------------------------------------------------------
    localparam int unsigned CLK_HZ = 40_000_000;
    localparam int unsigned SCLK_MAX_HZ = 16_000_000;
    localparam int unsigned FRAME_BITS = 16;
    localparam logic [4:0] FRAME_LEN = 5'h10;
    localparam logic [4:0] FRAME_OVR = 5'h11;
    // ------------------------------------------------------------
    // converter and filter timing, in serial clock periods
    // ------------------------------------------------------------
    localparam logic [6:0] SH_FAST = 7'h10;
    localparam logic [6:0] SH_SLOW = 7'h20;
    localparam logic [6:0] CONV_FAST = 7'h30;
    localparam logic [6:0] CONV_SLOW = 7'h60;
    localparam logic [2:0] FILT_SHORT = 3'h3;
    localparam logic [2:0] FILT_LONG = 3'h6;
    // ------------------------------------------------------------
    // bus map and interrupt bits
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_RXWORD = 8'h00;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h04;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h08;
    localparam logic [7:0] ADDR_STATE = 8'h0C;
    localparam int unsigned IRQ_W = 3;
    localparam int unsigned IRQ_RX = 0;
    localparam int unsigned IRQ_CONV = 1;
    localparam int unsigned IRQ_OVR = 2;
    // synchroniser lanes
    localparam int unsigned SYN_W = 9;
    localparam int unsigned S_SCLK = 0;
    localparam int unsigned S_CEN = 1;
    localparam int unsigned S_MOSI = 2;
    localparam int unsigned S_RSTN = 3;
    localparam int unsigned S_PWM = 4;
    localparam int unsigned S_ENC = 5;
    localparam int unsigned S_VSEL = 7;
    localparam int unsigned ENC_N = 2;
    // ------------------------------------------------------------
    // register layouts
    // ------------------------------------------------------------
    typedef struct packed {
        logic is_cfg;
        logic adc_start;
        logic [2:0] adc_chan;
        logic dir_a;
        logic [9:0] spare;
    } mcsc_norm_in_t;
    typedef struct packed {
        logic is_cfg;
        logic adc_slow;
        logic filt_long;
        logic dc_mode;
        logic stat_sel;
        logic [10:0] spare;
    } mcsc_cfg_in_t;
    typedef struct packed {
        logic is_stat;
        logic adc_valid;
        logic enc_b;
        logic enc_a;
        logic [2:0] adc_chan;
        logic rsvd;
        logic [7:0] adc_result;
    } mcsc_norm_out_t;
    typedef struct packed {
        logic is_stat;
        logic [6:0] rsvd;
        logic [7:0] fault;
    } mcsc_stat_out_t;
    localparam mcsc_norm_in_t NORM_RST = 16'h0000;
    localparam mcsc_cfg_in_t CFG_RST = 16'h8000;
    typedef enum logic [2:0] {
        ADC_IDLE = 3'b001,
        ADC_SAMPLE = 3'b010,
        ADC_CONV = 3'b100
    } mcsc_adc_st_t;
endpackage
`default_nettype wire

/* File: rtl/mcsc_top.sv */
`default_nettype none
module mcsc_top (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic clk_en_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic irq_o,
    input wire logic sclk_i,
    input wire logic chip_en_n_i,
    input wire logic mosi_i,
    output logic miso_o,
    output logic miso_oe_o,
    input wire logic rst_pin_n_i,
    input wire logic [1:0] core_volt_select_pin_i,
    output logic [1:0] core_volt_o,
    input wire logic [1:0] enc_cmp_i,
    input wire logic phase_a_pwm_input_i,
    output logic step_phase_a_out_o,
    output logic motor_c_out_a_o,
    output logic lowside_on_o,
    output logic adc_sample_o,
    output logic [2:0] adc_chan_o,
    input wire logic [7:0] adc_result_i,
    input wire logic [7:0] fault_i
);
    // ------------------------------------------------------------
    // pin synchronisers and edge finding
    // ------------------------------------------------------------
    // the serial clock is sampled, so it must stay below half of clk_i
    logic [mcsc_pkg::SYN_W-1:0] syn1_q, syn1_d, syn2_q, syn2_d;
    logic sclk_prev_q, sclk_prev_d, cen_prev_q, cen_prev_d;
    logic sclk_rise, cen_rise, cen_hi, dev_rst;
    always_comb begin
        syn1_d = {core_volt_select_pin_i, enc_cmp_i, phase_a_pwm_input_i, rst_pin_n_i,
                  mosi_i, chip_en_n_i, sclk_i};
        syn2_d = syn1_q;
        sclk_prev_d = syn2_q[mcsc_pkg::S_SCLK];
        cen_prev_d = syn2_q[mcsc_pkg::S_CEN];
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            syn1_q <= '0;
            syn2_q <= '0;
            sclk_prev_q <= 1'b0;
            cen_prev_q <= 1'b0;
        end else if (clk_en_i) begin
            syn1_q <= syn1_d;
            syn2_q <= syn2_d;
            sclk_prev_q <= sclk_prev_d;
            cen_prev_q <= cen_prev_d;
        end
    end
    assign sclk_rise = syn2_q[mcsc_pkg::S_SCLK] & ~sclk_prev_q;
    assign cen_hi = syn2_q[mcsc_pkg::S_CEN];
    assign cen_rise = cen_hi & ~cen_prev_q;
    // pin reset acts like the bus reset on all serial state
    assign dev_rst = rst_i | ~syn2_q[mcsc_pkg::S_RSTN];

    // ------------------------------------------------------------
    // power-up latch of the core voltage select
    // ------------------------------------------------------------
    // only rst_i (power-up) re-arms it; the reset pin does not
    logic [1:0] settle_q, settle_d, vsel_q, vsel_d;
    logic latched_q, latched_d;
    always_comb begin
        settle_d = {settle_q[0], 1'b1};
        vsel_d = vsel_q;
        latched_d = latched_q;
        if (settle_q[1] && !latched_q) begin
            vsel_d = syn2_q[mcsc_pkg::S_VSEL +: 2];
            latched_d = 1'b1;
        end
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            settle_q <= 2'h0;
            vsel_q <= 2'h0;
            latched_q <= 1'b0;
        end else if (clk_en_i) begin
            settle_q <= settle_d;
            vsel_q <= vsel_d;
            latched_q <= latched_d;
        end
    end
    assign core_volt_o = vsel_q;

    // ------------------------------------------------------------
    // encoder comparator filters
    // ------------------------------------------------------------
    mcsc_pkg::mcsc_cfg_in_t cfg_q, cfg_d;
    logic [2:0] filt_lim;
    logic [mcsc_pkg::ENC_N-1:0] fout_q;
    logic [2:0] fcnt_q [mcsc_pkg::ENC_N];
    assign filt_lim = cfg_q.filt_long ? mcsc_pkg::FILT_LONG : mcsc_pkg::FILT_SHORT;
    genvar gi;
    generate
        for (gi = 0; gi < mcsc_pkg::ENC_N; gi++) begin : g_filt
            logic fo_d;
            logic [2:0] fc_d;
            // input must hold for filt_lim serial clocks
            always_comb begin
                fo_d = fout_q[gi];
                fc_d = fcnt_q[gi];
                if (syn2_q[mcsc_pkg::S_ENC + gi] == fout_q[gi]) begin
                    fc_d = 3'h0;
                end else if (sclk_rise) begin
                    fc_d = fcnt_q[gi] + 3'h1;
                    if (fc_d >= filt_lim) begin
                        fo_d = syn2_q[mcsc_pkg::S_ENC + gi];
                        fc_d = 3'h0;
                    end
                end
            end
            always_ff @(posedge clk_i) begin
                if (dev_rst) begin
                    fout_q[gi] <= 1'b0;
                    fcnt_q[gi] <= 3'h0;
                end else if (clk_en_i) begin
                    fout_q[gi] <= fo_d;
                    fcnt_q[gi] <= fc_d;
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // serial shift engine and input registers
    // ------------------------------------------------------------
    mcsc_pkg::mcsc_norm_in_t norm_q, norm_d;
    mcsc_pkg::mcsc_norm_out_t nout;
    mcsc_pkg::mcsc_stat_out_t sout;
    logic [15:0] shift_q, shift_d, rx_q, rx_d, out_frame;
    logic [4:0] bitcnt_q, bitcnt_d;
    logic oe_q, oe_d, rx_evt, ovr_evt, start_evt, adc_valid_q;
    logic [7:0] result_q;
    logic [2:0] chan_q;
    // frame choice follows the config word
    always_comb begin
        nout = '{is_stat: 1'b0, adc_valid: adc_valid_q, enc_b: fout_q[1], enc_a: fout_q[0],
                 adc_chan: chan_q, rsvd: 1'b0, adc_result: result_q};
        sout = '{is_stat: 1'b1, rsvd: 7'h00, fault: fault_i};
        out_frame = cfg_q.stat_sel ? sout : nout;
    end
    always_comb begin
        shift_d = shift_q;
        rx_d = rx_q;
        bitcnt_d = bitcnt_q;
        norm_d = norm_q;
        cfg_d = cfg_q;
        rx_evt = 1'b0;
        ovr_evt = 1'b0;
        start_evt = 1'b0;
        // enable drops back high ends the word
        if (cen_rise) begin
            bitcnt_d = 5'h00;
            // only a whole 16-bit word is acted on
            if (bitcnt_q == mcsc_pkg::FRAME_LEN) begin
                rx_evt = 1'b1;
                if (rx_q[mcsc_pkg::FRAME_BITS-1]) begin
                    cfg_d = rx_q;
                end else begin
                    norm_d = rx_q;
                    start_evt = norm_d.adc_start;
                end
            end else if (bitcnt_q == mcsc_pkg::FRAME_OVR) begin
                ovr_evt = 1'b1;
            end
        end
        if (sclk_rise) begin
            // reload while idle, shift msb first while selected
            if (cen_hi) begin
                shift_d = out_frame;
                bitcnt_d = 5'h00;
            end else begin
                shift_d = {shift_q[14:0], 1'b0};
                rx_d = {rx_q[14:0], syn2_q[mcsc_pkg::S_MOSI]};
                if (bitcnt_q != mcsc_pkg::FRAME_OVR) begin
                    bitcnt_d = bitcnt_q + 5'h01;
                end
            end
        end
        oe_d = ~cen_hi;
    end
    // defaults and floated data out under reset
    always_ff @(posedge clk_i) begin
        if (dev_rst) begin
            shift_q <= 16'h0000;
            rx_q <= 16'h0000;
            bitcnt_q <= 5'h00;
            norm_q <= mcsc_pkg::NORM_RST;
            cfg_q <= mcsc_pkg::CFG_RST;
            oe_q <= 1'b0;
        end else if (clk_en_i) begin
            shift_q <= shift_d;
            rx_q <= rx_d;
            bitcnt_q <= bitcnt_d;
            norm_q <= norm_d;
            cfg_q <= cfg_d;
            oe_q <= oe_d;
        end
    end
    assign miso_o = shift_q[mcsc_pkg::FRAME_BITS-1];
    assign miso_oe_o = oe_q;

    // ------------------------------------------------------------
    // converter sequencer
    // ------------------------------------------------------------
    mcsc_pkg::mcsc_adc_st_t ast_q, ast_d;
    logic [6:0] acnt_q, acnt_d, sh_lim, conv_lim;
    logic [7:0] result_d;
    logic [2:0] chan_d;
    logic valid_d, sample_q, sample_d, conv_evt;
    assign sh_lim = cfg_q.adc_slow ? mcsc_pkg::SH_SLOW : mcsc_pkg::SH_FAST;
    assign conv_lim = cfg_q.adc_slow ? mcsc_pkg::CONV_SLOW : mcsc_pkg::CONV_FAST;
    always_comb begin
        ast_d = ast_q;
        acnt_d = acnt_q;
        result_d = result_q;
        chan_d = chan_q;
        valid_d = adc_valid_q;
        conv_evt = 1'b0;
        case (ast_q)
            mcsc_pkg::ADC_IDLE: begin
                if (start_evt) begin
                    ast_d = mcsc_pkg::ADC_SAMPLE;
                    acnt_d = 7'h00;
                    chan_d = norm_d.adc_chan;
                    valid_d = 1'b0;
                end
            end
            // acquisition ends at sh_lim serial clocks
            mcsc_pkg::ADC_SAMPLE: begin
                if (sclk_rise) begin
                    acnt_d = acnt_q + 7'h01;
                    if (acnt_d == sh_lim) begin
                        ast_d = mcsc_pkg::ADC_CONV;
                    end
                end
            end
            // result captured by conv_lim serial clocks
            mcsc_pkg::ADC_CONV: begin
                if (sclk_rise) begin
                    acnt_d = acnt_q + 7'h01;
                    if (acnt_d == conv_lim) begin
                        ast_d = mcsc_pkg::ADC_IDLE;
                        result_d = adc_result_i;
                        valid_d = 1'b1;
                        conv_evt = 1'b1;
                    end
                end
            end
            default: begin
                ast_d = mcsc_pkg::ADC_IDLE;
            end
        endcase
        sample_d = (ast_d == mcsc_pkg::ADC_SAMPLE);
    end
    always_ff @(posedge clk_i) begin
        if (dev_rst) begin
            ast_q <= mcsc_pkg::ADC_IDLE;
            acnt_q <= 7'h00;
            result_q <= 8'h00;
            chan_q <= 3'h0;
            adc_valid_q <= 1'b0;
            sample_q <= 1'b0;
        end else if (clk_en_i) begin
            ast_q <= ast_d;
            acnt_q <= acnt_d;
            result_q <= result_d;
            chan_q <= chan_d;
            adc_valid_q <= valid_d;
            sample_q <= sample_d;
        end
    end
    assign adc_sample_o = sample_q;
    assign adc_chan_o = chan_q;

    // ------------------------------------------------------------
    // phase A / motor C output and reset drive state
    // ------------------------------------------------------------
    logic step_q, step_d, motc_q, motc_d, low_q, low_d, drive;
    // mode picks the output, pwm pin gates it
    always_comb begin
        drive = norm_q.dir_a & syn2_q[mcsc_pkg::S_PWM];
        step_d = ~cfg_q.dc_mode & drive;
        motc_d = cfg_q.dc_mode & drive;
        low_d = 1'b0;
    end
    always_ff @(posedge clk_i) begin
        if (dev_rst) begin
            step_q <= 1'b0;
            motc_q <= 1'b0;
            low_q <= 1'b1;
        end else if (clk_en_i) begin
            step_q <= step_d;
            motc_q <= motc_d;
            low_q <= low_d;
        end
    end
    assign step_phase_a_out_o = step_q;
    assign motor_c_out_a_o = motc_q;
    assign lowside_on_o = low_q;

    // ------------------------------------------------------------
    // wishbone slave and interrupt
    // ------------------------------------------------------------
    function automatic logic hit(input logic [7:0] adr, input logic [7:0] off);
        hit = (adr[7:2] == off[7:2]);
    endfunction
    logic [mcsc_pkg::IRQ_W-1:0] stat_q, stat_d, mask_q, mask_d, evt;
    logic [31:0] dat_q, dat_d;
    logic [15:0] last_q, last_d;
    logic ack_q, ack_d, irq_q, irq_d, req;
    always_comb begin
        req = wb_cyc_i & wb_stb_i & ~ack_q;
        ack_d = req;
        evt = '0;
        evt[mcsc_pkg::IRQ_RX] = rx_evt;
        evt[mcsc_pkg::IRQ_CONV] = conv_evt;
        evt[mcsc_pkg::IRQ_OVR] = ovr_evt;
        last_d = rx_evt ? rx_q : last_q;
        mask_d = mask_q;
        stat_d = stat_q;
        dat_d = 32'h0000_0000;
        if (req && wb_we_i && wb_sel_i[0]) begin
            if (hit(wb_adr_i, mcsc_pkg::ADDR_IRQ_STAT)) begin
                stat_d = stat_q & ~wb_dat_i[mcsc_pkg::IRQ_W-1:0];
            end
            if (hit(wb_adr_i, mcsc_pkg::ADDR_IRQ_MASK)) begin
                mask_d = wb_dat_i[mcsc_pkg::IRQ_W-1:0];
            end
        end
        // new events win over a clear in the same cycle
        stat_d = stat_d | evt;
        if (req && !wb_we_i) begin
            if (hit(wb_adr_i, mcsc_pkg::ADDR_RXWORD)) begin
                dat_d = {16'h0000, last_q};
            end else if (hit(wb_adr_i, mcsc_pkg::ADDR_IRQ_STAT)) begin
                dat_d = {29'h0000_0000, stat_q};
            end else if (hit(wb_adr_i, mcsc_pkg::ADDR_IRQ_MASK)) begin
                dat_d = {29'h0000_0000, mask_q};
            end else if (hit(wb_adr_i, mcsc_pkg::ADDR_STATE)) begin
                dat_d = {cfg_q, 9'h000, latched_q, vsel_q, ast_q, adc_valid_q};
            end
        end
        irq_d = |(stat_d & mask_d);
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            stat_q <= '0;
            mask_q <= '0;
            dat_q <= 32'h0000_0000;
            last_q <= 16'h0000;
            ack_q <= 1'b0;
            irq_q <= 1'b0;
        end else if (clk_en_i) begin
            stat_q <= stat_d;
            mask_q <= mask_d;
            dat_q <= dat_d;
            last_q <= last_d;
            ack_q <= ack_d;
            irq_q <= irq_d;
        end
    end
    assign wb_dat_o = dat_q;
    assign wb_ack_o = ack_q;
    assign irq_o = irq_q;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i || !clk_en_i);
    property p_reload;
        sclk_rise && cen_hi && !dev_rst ##1 clk_en_i |-> shift_q == $past(out_frame);
    endproperty
    a_reload: assert property (p_reload) else $error("idle reload missed");
    property p_shift;
        sclk_rise && !cen_hi && !dev_rst ##1 clk_en_i |-> miso_o == $past(shift_q[14]);
    endproperty
    a_shift: assert property (p_shift) else $error("msb-first shift wrong");
    property p_norm;
        cen_rise && bitcnt_q == mcsc_pkg::FRAME_LEN && !rx_q[mcsc_pkg::FRAME_BITS-1] && !dev_rst
            |=> norm_q == $past(rx_q);
    endproperty
    a_norm: assert property (p_norm) else $error("primary word not stored");
    property p_cfg;
        cen_rise && bitcnt_q == mcsc_pkg::FRAME_LEN && rx_q[mcsc_pkg::FRAME_BITS-1] && !dev_rst
            |=> cfg_q == $past(rx_q);
    endproperty
    a_cfg: assert property (p_cfg) else $error("config word not stored");
    property p_rst; dev_rst |=> !miso_oe_o && lowside_on_o && !step_phase_a_out_o; endproperty
    a_rst: assert property (p_rst) else $error("reset drive state wrong");
    property p_vsel; latched_q |=> $stable(core_volt_o) && latched_q; endproperty
    a_vsel: assert property (p_vsel) else $error("core select changed after latch");
    sequence s_sh_end;
        ast_q == mcsc_pkg::ADC_SAMPLE && sclk_rise && acnt_q + 7'h01 == sh_lim;
    endsequence
    property p_sh; s_sh_end and !dev_rst |=> ast_q == mcsc_pkg::ADC_CONV; endproperty
    a_sh: assert property (p_sh) else $error("acquisition length wrong");
    property p_conv; ast_q == mcsc_pkg::ADC_CONV |-> acnt_q < conv_lim; endproperty
    a_conv: assert property (p_conv) else $error("conversion overran");
    property p_filt;
        !dev_rst && $changed(fout_q[0]) |-> $past(fcnt_q[0]) + 3'h1 == $past(filt_lim);
    endproperty
    a_filt: assert property (p_filt) else $error("filter released early");
    property p_mode; cfg_q.dc_mode && !dev_rst |=> !step_phase_a_out_o; endproperty
    a_mode: assert property (p_mode) else $error("stepper driven in dc mode");
    property p_frame; cen_hi && cfg_q.stat_sel |-> out_frame[15]; endproperty
    a_frame: assert property (p_frame) else $error("status frame tag missing");
endmodule
`default_nettype wire

/* File: testbench/mcsc_spi_model.sv */
`default_nettype none
module mcsc_spi_model (
    output logic sclk_o,
    output logic cen_n_o,
    output logic mosi_o,
    input wire logic miso_i
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        sclk_o = 1'b0;
        cen_n_o = 1'b1;
        mosi_o = 1'b0;
        forever #100 sclk_o = ~sclk_o;
    end
    task automatic xfer(input logic [15:0] w, output logic [15:0] r);
        @(negedge sclk_o);
        cen_n_o <= 1'b0;
        mosi_o <= w[15];
        r[15] = miso_i;
        for (int i = 14; i >= 0; i--) begin
            @(negedge sclk_o);
            r[i] = miso_i;
            mosi_o <= w[i];
        end
        @(negedge sclk_o);
        cen_n_o <= 1'b1;
        mosi_o <= ~w[0]; // idle line carries the inverse of the last bit
        repeat (3) @(negedge sclk_o);
    endtask
endmodule
`default_nettype wire

/* File: testbench/testbench.sv */
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i, rst_i, wb_cyc, wb_we, ack, irq, miso, miso_oe, sclk, cen_n, mosi;
    logic step_a, motor_c, lowside, adc_smp, pwm, rst_pin_n;
    logic [7:0] wb_adr, res, flt;
    logic [31:0] wb_wdat, wb_rdat, d;
    logic [1:0] vsel, vcore, enc;
    logic [2:0] chan;
    logic [15:0] r;
    int n_mismatch, n_tests, n, m;
    // bench clock
    initial begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end
    mcsc_spi_model u_mst (.sclk_o(sclk), .cen_n_o(cen_n), .mosi_o(mosi), .miso_i(miso));
    mcsc_top dut (.clk_i(clk_i), .rst_i(rst_i), .clk_en_i(1'b1), .wb_cyc_i(wb_cyc),
        .wb_stb_i(wb_cyc), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'hF),
        .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat), .wb_ack_o(ack), .irq_o(irq),
        .sclk_i(sclk), .chip_en_n_i(cen_n), .mosi_i(mosi), .miso_o(miso),
        .miso_oe_o(miso_oe), .rst_pin_n_i(rst_pin_n), .core_volt_select_pin_i(vsel),
        .core_volt_o(vcore), .enc_cmp_i(enc), .phase_a_pwm_input_i(pwm),
        .step_phase_a_out_o(step_a), .motor_c_out_a_o(motor_c), .lowside_on_o(lowside),
        .adc_sample_o(adc_smp), .adc_chan_o(chan), .adc_result_i(res), .fault_i(flt));
    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // one classic cycle; ack is seen at the edge before its own update lands
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] v);
        @(posedge clk_i);
        wb_cyc <= 1'b1;
        wb_we <= w;
        wb_adr <= a;
        wb_wdat <= v;
        @(posedge clk_i);
        while (ack !== 1'b1) @(posedge clk_i);
        d = wb_rdat;
        wb_cyc <= 1'b0;
    endtask
    task automatic stop_test();
        $display("mismatches %0d tests %0d", n_mismatch, n_tests);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_link();
        u_mst.xfer(16'h9800, r);
        wb(1'b0, mcsc_pkg::ADDR_RXWORD, 32'h0);
        check(d, 32'h0000_9800);
        wb(1'b1, mcsc_pkg::ADDR_IRQ_MASK, 32'h1);
        repeat (2) @(posedge clk_i);
        check(irq, 1'b1);
        wb(1'b1, mcsc_pkg::ADDR_IRQ_STAT, 32'h1);
        repeat (2) @(posedge clk_i);
        check(irq, 1'b0);
        // data out must be driven while the enable is low
        fork
            u_mst.xfer(16'h9800, r);
            begin
                wait (cen_n === 1'b0);
                repeat (8) @(posedge clk_i);
                check(miso_oe, 1'b1);
            end
        join
        check(r, {16'h0, 1'b1, 7'h0, flt});
    endtask
    task automatic t_motor();
        u_mst.xfer(16'h0400, r);
        check(motor_c, 1'b0);
        @(posedge clk_i);
        pwm <= 1'b1;
        repeat (6) @(posedge clk_i);
        check({motor_c, step_a}, 2'b10);
        u_mst.xfer(16'h8000, r);
        check({motor_c, step_a}, 2'b01);
    endtask
    // acquisition and conversion counted in serial clock rises
    task automatic t_adc();
        wb(1'b1, mcsc_pkg::ADDR_IRQ_MASK, 32'h2);
        // counting runs beside the transfer, since the start lands before it returns
        fork
            u_mst.xfer(16'h6C00, r);
            begin
                while (adc_smp !== 1'b1) @(posedge clk_i);
                n = 0;
                m = 0;
                while (adc_smp === 1'b1) begin
                    @(posedge sclk);
                    n++;
                end
                while (irq !== 1'b1) begin
                    @(posedge sclk);
                    m++;
                end
            end
        join
        check(n >= 15 && n <= 17, 1'b1);
        check(n + m >= 44 && n + m <= 50, 1'b1);
        check(chan, 3'h5);
        u_mst.xfer(16'h0400, r);
        check(r, 16'h5AA5);
    endtask
    // device reset pin in mid-run: safe drive state, defaults, latch kept
    task automatic t_pinrst();
        @(posedge clk_i);
        rst_pin_n <= 1'b0;
        repeat (4) @(posedge clk_i);
        check({lowside, miso_oe, step_a, motor_c}, 4'h8);
        rst_pin_n <= 1'b1;
        repeat (40) @(posedge clk_i);
        // the pin reset must not re-arm the core select latch
        check({vcore, lowside}, 3'h4);
        u_mst.xfer(16'h0000, r);
        check(r, 16'h1000);
    endtask
    // ------------------------------------------------------------
    // main sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        rst_i = 1'b1;
        wb_cyc = 1'b0;
        wb_we = 1'b0;
        wb_adr = 8'h00;
        wb_wdat = 32'h0;
        vsel = 2'h2;
        pwm = 1'b0;
        rst_pin_n = 1'b1;
        enc = 2'h1;
        res = 8'hA5;
        flt = 8'h3C;
        n_mismatch = 0;
        n_tests = 0;
        repeat (16) @(posedge clk_i);
        check({lowside, miso_oe, step_a, motor_c}, 4'h8);
        rst_i <= 1'b0;
        repeat (8) @(posedge clk_i);
        vsel <= 2'h1;
        repeat (8) @(posedge clk_i);
        check({vcore, lowside}, 3'h4);
        wb(1'b0, 8'hF0, 32'h0);
        check(d, 32'h0);
        t_link();
        t_motor();
        t_adc();
        t_pinrst();
        stop_test();
    end
    // watchdog, well past the expected run of about 40 us
    initial begin
        #200000;
        n_mismatch++;
        stop_test();
    end
endmodule
`default_nettype wire
